// file: hw/mcfs_supervisor.sv
// Main clock failure supervisor with Avalon-MM register slave
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps

// Notes on behaviour
// - Sample main clock, request reset on failure
// - No main edge in four cycles fails
// - Supervision starts only after enable written
// - Enable cannot be cleared by software
// - Any reset clears the enable bit
// - Pause in STOP and stabilisation time
// - Keep monitoring in HALT and idle modes
// - Oscillator stoppable option is fixed input
// - Stopped internal oscillator stops supervision
// - Oscillator restart resumes supervision automatically
// - Failure gives reset or NMI by selection
// - Keep readable reset source flags
// - Set supervisor flag when reset requested
// - Run from internal oscillator after reset
module mcfs_supervisor (
   input  wire logic        sys_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        por_rstn_i,
   input  wire logic [7:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        main_clk_i,
   input  wire logic        stop_mode_i,
   input  wire logic        iosc_stoppable_i,
   input  wire logic        wdt_reset_i,
   input  wire logic        lvd_reset_i,
   output logic             rst_req_o,
   output logic             nmi_o,
   output logic             irq_o,
   output logic             iosc_run_o,
   output logic             cpu_clk_main_o,
   output logic             monitoring_o
);
   import mcfs_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic                main_s;
   logic                prev_q;
   logic                prev_d;
   logic                main_edge;
   logic                opt_q;
   logic                opt_d;
   logic                opt_done_q;
   logic                opt_done_d;
   logic                en_q;
   logic                en_d;
   logic                nmi_sel_q;
   logic                nmi_sel_d;
   logic                iosc_stop_q;
   logic                iosc_stop_d;
   logic                main_sel_q;
   logic                main_sel_d;
   logic                iosc_off;
   mcfs_state_t         st_q;
   mcfs_state_t         resume_st;
   mcfs_state_t         st_d;
   logic [WIN_W-1:0]    cnt_q;
   logic [WIN_W-1:0]    cnt_d;
   logic [OST_W-1:0]    ost_q;
   logic [OST_W-1:0]    ost_d;
   logic                req_q;
   logic                req_d;
   logic                nmi_q;
   logic                nmi_d;
   logic                fail_evt;
   logic                res_evt;
   logic [INT_W-1:0]    int_stat_q;
   logic [INT_W-1:0]    int_stat_d;
   logic [INT_W-1:0]    int_mask_q;
   logic [INT_W-1:0]    int_mask_d;
   logic [RSRC_W-1:0]   rsrc_q;
   logic [RSRC_W-1:0]   rsrc_d;
   logic                ack_q;
   logic                ack_d;
   logic [31:0]         rdata_q;
   logic [31:0]         rdata_d;
   logic                req_pend;
   logic                wr_acc;
   logic                wr_ctrl;
   logic                wr_rsrc;
   logic                wr_istat;
   logic                wr_imask;

   // ------------------------------------------------------------
   // Main clock sampling
   // ------------------------------------------------------------
   mcfs_sync u_main_sync (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .d_i       (main_clk_i),
      .q_o       (main_s)
   );

   always_comb begin
      prev_d = main_s;
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
      end
   end

   assign main_edge = main_s ^ prev_q;

   // ------------------------------------------------------------
   // Oscillator option capture
   // ------------------------------------------------------------
   always_comb begin
      opt_d      = opt_done_q ? opt_q : iosc_stoppable_i;
      opt_done_d = 1'b1;
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         opt_q      <= 1'b0;
         opt_done_q <= 1'b0;
      end else begin
         opt_q      <= opt_d;
         opt_done_q <= opt_done_d;
      end
   end

   // ------------------------------------------------------------
   // Bus strobes
   // ------------------------------------------------------------
   assign req_pend = avs_read_i | avs_write_i;
   assign wr_acc   = avs_write_i & ack_q;
   assign wr_ctrl  = wr_acc & (avs_address_i == ADDR_CTRL);
   assign wr_rsrc  = wr_acc & (avs_address_i == ADDR_RSTSRC);
   assign wr_istat = wr_acc & (avs_address_i == ADDR_INT_STAT);
   assign wr_imask = wr_acc & (avs_address_i == ADDR_INT_MASK);

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   always_comb begin
      en_d        = en_q;
      nmi_sel_d   = nmi_sel_q;
      iosc_stop_d = iosc_stop_q;
      main_sel_d  = main_sel_q;
      if (wr_ctrl) begin
         en_d        = en_q | avs_writedata_i[CTRL_EN_BIT];
         nmi_sel_d   = avs_writedata_i[CTRL_NMI_BIT];
         iosc_stop_d = avs_writedata_i[CTRL_IOSC_STP_BIT];
         main_sel_d  = avs_writedata_i[CTRL_MAIN_SEL_BIT];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         en_q        <= 1'b0;
         nmi_sel_q   <= 1'b0;
         iosc_stop_q <= 1'b0;
         main_sel_q  <= 1'b0;
      end else begin
         en_q        <= en_d;
         nmi_sel_q   <= nmi_sel_d;
         iosc_stop_q <= iosc_stop_d;
         main_sel_q  <= main_sel_d;
      end
   end

   assign iosc_off       = opt_q & iosc_stop_q;
   assign iosc_run_o     = ~iosc_off;
   assign cpu_clk_main_o = main_sel_q;

   // ------------------------------------------------------------
   // Supervision state machine
   // ------------------------------------------------------------
   always_comb begin
      st_d     = st_q;
      cnt_d    = cnt_q;
      ost_d    = ost_q;
      req_d    = req_q;
      nmi_d    = 1'b0;
      fail_evt = 1'b0;
      res_evt  = 1'b0;
      resume_st = SUP_MON;
      if (stop_mode_i) begin
         resume_st = SUP_STOP;
      end else if (iosc_off) begin
         resume_st = SUP_IOSC;
      end
      case (st_q)
         SUP_OFF: begin
            if (en_q) begin
               st_d = resume_st;
            end
         end
         SUP_MON: begin
            if (stop_mode_i) begin
               st_d = SUP_STOP;
            end else if (iosc_off) begin
               st_d = SUP_IOSC;
            end else if (main_edge) begin
               cnt_d = '0;
            end else if (cnt_q == WIN_W'(SUPV_WINDOW_CYC - 1)) begin
               st_d = SUP_FAIL;
            end else begin
               cnt_d = cnt_q + WIN_W'(1);
            end
         end
         SUP_STOP: begin
            if (!stop_mode_i) begin
               st_d  = SUP_STAB;
               ost_d = '0;
            end
         end
         SUP_STAB: begin
            if (stop_mode_i) begin
               st_d = SUP_STOP;
            end else if (ost_q == OST_W'(OSC_STAB_CYC - 1)) begin
               st_d  = resume_st;
               cnt_d = '0;
            end else begin
               ost_d = ost_q + OST_W'(1);
            end
         end
         SUP_IOSC: begin
            if (!iosc_off) begin
               st_d    = resume_st;
               cnt_d   = '0;
               res_evt = 1'b1;
            end
         end
         SUP_FAIL: begin
            fail_evt = ~req_q;
            if (nmi_sel_q) begin
               nmi_d = 1'b1;
               st_d  = resume_st;
               cnt_d = '0;
            end else begin
               req_d = 1'b1;
            end
         end
         default: begin
            st_d = SUP_OFF;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q  <= SUP_OFF;
         cnt_q <= '0;
         ost_q <= '0;
         req_q <= 1'b0;
         nmi_q <= 1'b0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         ost_q <= ost_d;
         req_q <= req_d;
         nmi_q <= nmi_d;
      end
   end

   assign rst_req_o    = req_q;
   assign nmi_o        = nmi_q;
   assign monitoring_o = (st_q == SUP_MON);

   // ------------------------------------------------------------
   // Interrupt status and mask
   // ------------------------------------------------------------
   always_comb begin
      int_stat_d = int_stat_q;
      int_mask_d = int_mask_q;
      if (wr_istat) begin
         int_stat_d = int_stat_q & ~avs_writedata_i[INT_W-1:0];
      end
      int_stat_d[INT_FAIL_BIT] = int_stat_d[INT_FAIL_BIT] | fail_evt;
      int_stat_d[INT_RES_BIT]  = int_stat_d[INT_RES_BIT] | res_evt;
      if (wr_imask) begin
         int_mask_d = avs_writedata_i[INT_W-1:0];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         int_stat_q <= INT_RST;
         int_mask_q <= INT_RST;
      end else begin
         int_stat_q <= int_stat_d;
         int_mask_q <= int_mask_d;
      end
   end

   assign irq_o = |(int_stat_q & int_mask_q);

   // ------------------------------------------------------------
   // Reset source flags, kept across chip resets
   // ------------------------------------------------------------
   always_comb begin
      rsrc_d = rsrc_q;
      if (wr_rsrc) begin
         rsrc_d = rsrc_q & ~avs_writedata_i[RSRC_W-1:0];
      end
      rsrc_d[RSRC_WDT_BIT] = rsrc_d[RSRC_WDT_BIT] | wdt_reset_i;
      rsrc_d[RSRC_LVD_BIT] = rsrc_d[RSRC_LVD_BIT] | lvd_reset_i;
      rsrc_d[RSRC_CLK_BIT] = rsrc_d[RSRC_CLK_BIT] | req_q;
   end

   always_ff @(posedge sys_clk_i or negedge por_rstn_i) begin
      if (!por_rstn_i) begin
         rsrc_q <= RSRC_RST;
      end else begin
         rsrc_q <= rsrc_d;
      end
   end

   // ------------------------------------------------------------
   // Avalon-MM slave, one wait state
   // ------------------------------------------------------------
   always_comb begin
      ack_d   = req_pend & ~ack_q;
      rdata_d = rdata_q;
      if (avs_read_i & ~ack_q) begin
         rdata_d = RD_ZERO;
         if (avs_address_i == ADDR_CTRL) begin
            rdata_d[CTRL_EN_BIT]       = en_q;
            rdata_d[CTRL_NMI_BIT]      = nmi_sel_q;
            rdata_d[CTRL_IOSC_STP_BIT] = iosc_stop_q;
            rdata_d[CTRL_MAIN_SEL_BIT] = main_sel_q;
         end else if (avs_address_i == ADDR_STATUS) begin
            rdata_d[STAT_MON_BIT]  = (st_q == SUP_MON);
            rdata_d[STAT_OPT_BIT]  = opt_q;
            rdata_d[STAT_STAB_BIT] = (st_q == SUP_STAB);
            rdata_d[STAT_IOSC_BIT] = ~iosc_off;
            rdata_d[STAT_REQ_BIT]  = req_q;
         end else if (avs_address_i == ADDR_RSTSRC) begin
            rdata_d[RSRC_W-1:0] = rsrc_q;
         end else if (avs_address_i == ADDR_INT_STAT) begin
            rdata_d[INT_W-1:0] = int_stat_q;
         end else if (avs_address_i == ADDR_INT_MASK) begin
            rdata_d[INT_W-1:0] = int_mask_q;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_q   <= 1'b0;
         rdata_q <= RD_ZERO;
      end else begin
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   assign avs_waitrequest_o = req_pend & ~ack_q;
   assign avs_readdata_o    = rdata_q;

endmodule

// file: hw/mcfs_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module mcfs_sync (
   input  wire logic sys_clk_i,
   input  wire logic rstn_i,
   input  wire logic d_i,
   output logic      q_o
);

   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   always_comb begin
      meta_d = d_i;
      sync_d = meta_q;
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign q_o = sync_q;

endmodule

// file: pkg/mcfs_pkg.sv
// Constants shared by the main clock failure supervisor
package mcfs_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 10;
   // Supervision window in internal oscillator cycles
   localparam int SUPV_WINDOW_CYC = 4;
   localparam int WIN_W           = 3;
   // Oscillation stabilisation time after STOP release
   localparam int OSC_STAB_NS     = 10000;
   localparam int OSC_STAB_CYC    = (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OST_W           = 11;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_RSTSRC   = 8'h08;
   localparam logic [7:0] ADDR_INT_STAT = 8'h0C;
   localparam logic [7:0] ADDR_INT_MASK = 8'h10;

   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int CTRL_EN_BIT       = 0;
   localparam int CTRL_NMI_BIT      = 1;
   localparam int CTRL_IOSC_STP_BIT = 2;
   localparam int CTRL_MAIN_SEL_BIT = 3;

   // ------------------------------------------------------------
   // Status register fields
   // ------------------------------------------------------------
   localparam int STAT_MON_BIT  = 0;
   localparam int STAT_OPT_BIT  = 1;
   localparam int STAT_STAB_BIT = 2;
   localparam int STAT_IOSC_BIT = 3;
   localparam int STAT_REQ_BIT  = 4;

   // ------------------------------------------------------------
   // Reset source flags and interrupt fields
   // ------------------------------------------------------------
   localparam int RSRC_WDT_BIT = 0;
   localparam int RSRC_LVD_BIT = 1;
   localparam int RSRC_CLK_BIT = 2;
   localparam int RSRC_W       = 3;
   localparam int INT_FAIL_BIT = 0;
   localparam int INT_RES_BIT  = 1;
   localparam int INT_W        = 2;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [31:0] RD_ZERO        = 32'h0000_0000;
   localparam logic [INT_W-1:0] INT_RST   = 2'h0;
   localparam logic [RSRC_W-1:0] RSRC_RST = 3'h0;

   typedef enum logic [2:0] {
      SUP_OFF   = 3'b000,
      SUP_MON   = 3'b001,
      SUP_STOP  = 3'b010,
      SUP_STAB  = 3'b011,
      SUP_IOSC  = 3'b100,
      SUP_FAIL  = 3'b101
   } mcfs_state_t;

endpackage

// file: test/mcfs_rst_model.sv
// Reset controller model answering the supervisor's reset request
`timescale 1ns/1ps
module mcfs_rst_model #(
   parameter int HOLD = 8
) (
   input  wire logic sys_clk_i,
   input  wire logic ext_rstn_i,
   input  wire logic rst_req_i,
   output logic      rstn_o
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;

   // ------------------------------------------------------------
   // Reset pulse of HOLD cycles per request
   // ------------------------------------------------------------
   always_comb begin
      cnt_d = cnt_q;
      if (cnt_q != 8'h00) begin
         cnt_d = cnt_q - 8'h01;
      end else if (rst_req_i) begin
         cnt_d = 8'(HOLD);
      end
   end

   always_ff @(posedge sys_clk_i or negedge ext_rstn_i) begin
      if (!ext_rstn_i) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign rstn_o = ext_rstn_i && (cnt_q == 8'h00);
endmodule

// file: test/mcfs_supervisor_asserts.sv
// Assertion checker for the main clock failure supervisor
`timescale 1ns/1ps
module mcfs_sva (
   input wire logic       sys_clk_i,
   input wire logic       rstn_i,
   input wire logic [7:0] avs_address_i,
   input wire logic       avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic       avs_waitrequest_o,
   input wire logic       main_clk_i,
   input wire logic       stop_mode_i,
   input wire logic       rst_req_o,
   input wire logic       nmi_o,
   input wire logic       iosc_run_o,
   input wire logic       cpu_clk_main_o,
   input wire logic       monitoring_o
);
   import mcfs_pkg::*;
   logic       en_q;
   logic       en_d;
   logic       prev_q;
   logic [3:0] still_q;
   logic [3:0] still_d;

   // ------------------------------------------------------------
   // Helper state
   // ------------------------------------------------------------
   always_comb begin
      en_d = en_q | (avs_write_i & ~avs_waitrequest_o & (avs_address_i == ADDR_CTRL)
             & avs_writedata_i[CTRL_EN_BIT]);
      still_d = (monitoring_o && main_clk_i == prev_q) ? still_q + 4'h1 : 4'h0;
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         en_q    <= 1'b0;
         prev_q  <= 1'b0;
         still_q <= 4'h0;
      end else begin
         en_q    <= en_d;
         prev_q  <= main_clk_i;
         still_q <= still_d;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_fail_bound: assert property (still_q < 4'ha)
      else $error("stopped main clock not detected in time");
   a_req_held: assert property (rst_req_o |=> rst_req_o)
      else $error("reset request dropped before reset");
   a_enable_first: assert property ($rose(monitoring_o) |-> en_q)
      else $error("monitoring without enable write");
   a_stop_pause: assert property (stop_mode_i |=> !monitoring_o)
      else $error("monitoring during stop mode");
   a_stab_pause: assert property ($fell(stop_mode_i) |-> !monitoring_o [*8])
      else $error("monitoring during stabilisation");
   a_iosc_pause: assert property (!iosc_run_o |=> !monitoring_o)
      else $error("monitoring with oscillator stopped");
   a_iosc_resume: assert property ($rose(iosc_run_o) && en_q && !stop_mode_i |-> ##[1:4] monitoring_o)
      else $error("supervision not resumed");
   a_nmi_pulse: assert property (nmi_o |-> !rst_req_o ##1 !nmi_o)
      else $error("nmi not a lone pulse");
   a_cpu_int_clk: assert property ($rose(rstn_i) |-> !cpu_clk_main_o)
      else $error("cpu not on internal clock after reset");
   a_rst_clears: assert property ($rose(rstn_i) |-> !monitoring_o ##1 !monitoring_o)
      else $error("monitoring right after reset");

   c_req: cover property ($rose(rst_req_o));
   c_nmi: cover property (nmi_o);
   c_resume: cover property ($rose(iosc_run_o) && en_q);
endmodule

bind mcfs_supervisor mcfs_sva u_sva (
   .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o), .main_clk_i(main_clk_i),
   .stop_mode_i(stop_mode_i), .rst_req_o(rst_req_o), .nmi_o(nmi_o), .iosc_run_o(iosc_run_o),
   .cpu_clk_main_o(cpu_clk_main_o), .monitoring_o(monitoring_o)
);

// file: test/mcfs_supervisor_tb.sv
// Self-checking testbench for the main clock failure supervisor
`timescale 1ns/1ps
module mcfs_supervisor_tb;
   import mcfs_pkg::*;
   logic        clk, ext_rstn, rstn, por_rstn, rd, wr, mclk, mrun, stop, wdt, lvd;
   logic        wreq, req, nmi, irq, irun, cmain, mon, strap;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, rv;
   int          n_errors, num_checks, n;

   mcfs_rst_model u_rst (.sys_clk_i(clk), .ext_rstn_i(ext_rstn), .rst_req_i(req), .rstn_o(rstn));
   mcfs_supervisor u_dut (.sys_clk_i(clk), .rstn_i(rstn), .por_rstn_i(por_rstn), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .main_clk_i(mclk), .stop_mode_i(stop), .iosc_stoppable_i(strap),
      .wdt_reset_i(wdt), .lvd_reset_i(lvd), .rst_req_o(req), .nmi_o(nmi), .irq_o(irq),
      .iosc_run_o(irun), .cpu_clk_main_o(cmain), .monitoring_o(mon));

   // ------------------------------------------------------------
   // Clocks and shared tasks
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (mrun) mclk <= ~mclk;

   task automatic cyc(input int c);
      repeat (c) @(posedge clk);
   endtask
   task automatic chk(input logic g, input logic e, input string s);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %0t %s got %b", $time, s, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      addr  <= a;
      wr    <= w;
      rd    <= !w;
      wdata <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      rv = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic test_done;
      if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      bus(0, ADDR_CTRL, 32'h0000_0000);
      chk(|rv, 1'b0, "ctrl reset");
      chk(cmain, 1'b0, "cpu clock");
      bus(0, 8'h14, 32'h0000_0000);
      chk(|rv, 1'b0, "unmapped");
   endtask
   task automatic t_enable;
      cyc(20);
      chk(req | mon, 1'b0, "idle disabled");
      mrun <= 1'b1;
      bus(1, ADDR_CTRL, 32'h0000_0001);
      cyc(4);
      chk(mon, 1'b1, "monitoring");
      bus(1, ADDR_CTRL, 32'h0000_0000);
      bus(0, ADDR_CTRL, 32'h0000_0000);
      chk(rv[CTRL_EN_BIT], 1'b1, "enable lock");
      bus(1, ADDR_STATUS, 32'h0000_0000);
      bus(0, ADDR_STATUS, 32'h0000_0000);
      chk(rv[STAT_OPT_BIT], 1'b1, "option fixed");
      cyc(50);
      chk(mon & !req, 1'b1, "halt keeps monitoring");
   endtask
   task automatic t_stop;
      stop <= 1'b1;
      mrun <= 1'b0;
      cyc(30);
      chk(mon | req, 1'b0, "stop pause");
      stop <= 1'b0;
      cyc(500);
      bus(0, ADDR_STATUS, 32'h0000_0000);
      chk(rv[STAT_STAB_BIT] & !req, 1'b1, "stabilising");
      mrun <= 1'b1;
      cyc(600);
      chk(mon, 1'b1, "after stabilisation");
   endtask
   task automatic t_iosc;
      bus(1, ADDR_CTRL, 32'h0000_0005);
      chk(irun, 1'b0, "iosc stopped");
      mrun <= 1'b0;
      cyc(30);
      chk(mon | req, 1'b0, "no supervision");
      mrun <= 1'b1;
      cyc(4);
      bus(1, ADDR_CTRL, 32'h0000_0001);
      cyc(3);
      chk(mon & !irq, 1'b1, "resumed masked");
      bus(1, ADDR_INT_MASK, 32'h0000_0002);
      chk(irq, 1'b1, "irq unmasked");
      bus(1, ADDR_INT_STAT, 32'h0000_0002);
      chk(irq, 1'b0, "irq cleared");
   endtask
   task automatic t_nmi;
      bus(1, ADDR_CTRL, 32'h0000_0003);
      mrun <= 1'b0;
      n = 0;
      while (nmi !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk(nmi & !req, 1'b1, "nmi mode");
      mrun <= 1'b1;
      bus(0, ADDR_INT_STAT, 32'h0000_0000);
      chk(rv[INT_FAIL_BIT], 1'b1, "failure event");
      bus(0, ADDR_RSTSRC, 32'h0000_0000);
      chk(rv[RSRC_CLK_BIT], 1'b0, "no flag in nmi mode");
      bus(1, ADDR_INT_STAT, 32'h0000_0003);
   endtask
   task automatic t_fail;
      strap <= 1'b0;
      bus(1, ADDR_CTRL, 32'h0000_0009);
      chk(cmain, 1'b1, "main clock selected");
      cyc(8);
      mrun <= 1'b0;
      n = 0;
      while (req !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk(n >= SUPV_WINDOW_CYC && n <= SUPV_WINDOW_CYC + 8, 1'b1, "window");
      chk(req, 1'b1, "reset request");
      cyc(3);
      chk(rstn, 1'b0, "reset taken");
      while (rstn !== 1'b1) @(posedge clk);
      mrun <= 1'b1;
      wdt  <= 1'b1;
      lvd  <= 1'b1;
      @(posedge clk);
      wdt <= 1'b0;
      lvd <= 1'b0;
      bus(0, ADDR_RSTSRC, 32'h0000_0000);
      chk(&rv[2:0], 1'b1, "reset sources");
      bus(0, ADDR_CTRL, 32'h0000_0000);
      chk(|rv | cmain, 1'b0, "after own reset");
      bus(1, ADDR_RSTSRC, 32'h0000_0007);
      bus(0, ADDR_RSTSRC, 32'h0000_0000);
      chk(|rv, 1'b0, "flags cleared");
      bus(1, ADDR_CTRL, 32'h0000_0004);
      bus(0, ADDR_STATUS, 32'h0000_0000);
      chk(rv[STAT_OPT_BIT] | !irun, 1'b0, "option not stoppable");
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      {ext_rstn, por_rstn, rd, wr, mclk, mrun, stop, wdt, lvd} = 9'h000;
      addr       = 8'h00;
      wdata      = 32'h0000_0000;
      strap      = 1'b1;
      n_errors   = 0;
      num_checks = 0;
      cyc(20);
      ext_rstn <= 1'b1;
      por_rstn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_enable();
      t_stop();
      t_iosc();
      t_nmi();
      t_fail();
      test_done();
   end
   initial begin
      #100_000;
      n_errors++;
      test_done();
   end
endmodule
